// ---- rtl/byte_buffer.v ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; both outputs toward each side come from flip-flops.
`timescale 1ns/1ps
module byte_buffer #(
  parameter WIDTH = 9
) (
  input wire clk, // System clock
  input wire nrst, // Asynchronous reset, active low
  input wire s_valid, // Word offered
  output reg s_ready, // Room for a word
  input wire [WIDTH-1:0] s_data, // Word in
  output reg m_valid, // Head word present
  input wire m_ready, // Head word taken
  output reg [WIDTH-1:0] m_data // Head word
);
  reg tail_valid;
  reg [WIDTH-1:0] tail_data;
  reg next_head_valid;
  reg next_tail_valid;
  reg [WIDTH-1:0] next_head_data;
  reg [WIDTH-1:0] next_tail_data;
  wire push;
  wire pop;

  assign push = s_valid & s_ready;
  assign pop = m_valid & m_ready;

  always @* begin
    next_head_valid = m_valid;
    next_tail_valid = tail_valid;
    next_head_data = m_data;
    next_tail_data = tail_data;
    if (pop) begin
      next_head_valid = tail_valid;
      next_head_data = tail_data;
      next_tail_valid = 1'b0;
    end
    if (push) begin
      if (!next_head_valid) begin
        next_head_valid = 1'b1;
        next_head_data = s_data;
      end else begin
        next_tail_valid = 1'b1;
        next_tail_data = s_data;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_valid <= 1'b0;
      tail_valid <= 1'b0;
      m_data <= {WIDTH{1'b0}};
      tail_data <= {WIDTH{1'b0}};
      s_ready <= 1'b1;
    end else begin
      m_valid <= next_head_valid;
      tail_valid <= next_tail_valid;
      m_data <= next_head_data;
      tail_data <= next_tail_data;
      // Registered room flag keeps the source side free of combinational paths
      s_ready <= ~next_tail_valid;
    end
  end
endmodule

// ---- rtl/stall_timer.v ----
// Down counter bounding how long a fast handshake access may be held off.
// Assumes start is a one-cycle pulse; expired stays high until the next start.
`timescale 1ns/1ps
`include "wsbt_map.vh"
module stall_timer #(
  parameter CNT_W = `WS_STALL_CNT_W,
  parameter [CNT_W-1:0] LIMIT = `WS_STALL_CYCLES
) (
  input wire clk, // System clock
  input wire nrst, // Asynchronous reset, active low
  input wire start, // Load the limit and begin counting
  output reg expired // Limit reached
);
  reg [CNT_W-1:0] count;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= {CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (start) begin
      count <= LIMIT - 1'b1;
      expired <= 1'b0;
    end else if (count != {CNT_W{1'b0}}) begin
      count <= count - 1'b1;
      expired <= (count == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// ---- rtl/word_serial_byte_transfer.v ----
// Servant side of the word serial byte transfer protocol with fast handshake.
// Assumes the commander's low data register accesses arrive as one-cycle strobes
// synchronous to clk, and the device core drains rx and fills tx.
`timescale 1ns/1ps
`include "wsbt_map.vh"
// Function
// - Only byte opcodes are data; all other commands pass to the command handler.
// - Only the byte transfer protocol is implemented, so one protocol is active.
// - Inbound bytes come inside commands; outbound bytes only answer fetch queries.
// - Send-byte carries 8 bits in; fetch-byte returns 8 bits out.
// - Input-ready is high exactly when a send-byte can be taken.
// - Output-ready is high exactly when a byte is available to fetch.
// - Write-ready stays low until input-ready has dropped after a send-byte; the code raises it once input-ready updates, even if room remains.
// - Write-ready stays low until output-ready has dropped after a fetch-byte; the code raises it once output-ready updates, even if a byte remains.
// - Input-ready and output-ready never fall while write-ready is high.
// - Both byte commands are accepted through fast handshake transfers.
// - Fast mode is entered only when ready for the byte command.
// - Fast mode ends when a message-end byte is sent or fetched.
// - An unready byte command under fast capability gets a bus error, flags kept.
// - A fast access stalls at most 20 us, then gets a bus error.
// - A bus error leaves buffers untouched and ends fast mode.
module word_serial_byte_transfer (
  input wire clk, // System clock, 100 MHz
  input wire nrst, // Asynchronous reset, active low
  input wire cmd_write, // Command word written, one-cycle strobe
  input wire [15:0] cmd_word, // Command word
  input wire cmd_fast, // Commander uses fast handshake for this access
  input wire resp_read, // Commander read the low data register
  output reg cmd_ack, // Access completed, one-cycle pulse
  output reg cmd_berr, // Access ended in bus error, one-cycle pulse
  output reg [15:0] data_low, // Response word: end bit and data byte
  output reg write_ready, // Response flag: next command may be written
  output reg read_ready, // Response flag: response waiting
  output reg input_ready, // Response flag: send-byte can be processed
  output reg output_ready_flag, // Response flag: fetch-byte can be served
  output reg err_n, // Response flag: protocol error, active low
  output reg fast_mode_active_n, // Response flag: fast mode active, active low
  input wire fast_capable, // Device supports fast handshake
  input wire fast_request, // Device asks to enter fast mode, pulse
  input wire err_clear, // Error reported and cleared, pulse
  output reg other_valid, // Non-byte command for the handler, pulse
  output reg [15:0] other_word, // Non-byte command word
  output wire rx_valid, // Received byte present
  input wire rx_ready, // Device takes received byte
  output wire [7:0] rx_data, // Received byte
  output wire rx_end, // Received byte ends a message
  input wire tx_valid, // Device offers byte to send
  output wire tx_ready, // Room for byte to send
  input wire [7:0] tx_data, // Byte to send
  input wire tx_end // Byte to send ends a message
);
  localparam ST_IDLE = 2'd0;
  localparam ST_STALL = 2'd1;
  localparam ST_SETTLE = 2'd2;
  localparam ST_RELEASE = 2'd3;

  reg [1:0] state;
  reg [15:0] held_word;
  reg in_push;
  reg [8:0] in_word;
  reg out_pop;
  reg fetch_pending;
  reg timer_start;
  wire in_room;
  wire [8:0] rx_word;
  wire rx_word_valid;
  wire out_valid;
  wire [8:0] out_word;
  wire timer_expired;
  wire [15:0] cur_word;
  wire [`WS_OP_W-1:0] cur_op;
  wire is_send;
  wire is_fetch;
  wire unready;

  assign cur_word = (state == ST_STALL) ? held_word : cmd_word;
  assign cur_op = cur_word[`WS_OP_MSB:`WS_OP_LSB];
  assign is_send = (cur_op == `WS_OP_SEND_BYTE);
  assign is_fetch = (cur_op == `WS_OP_FETCH_BYTE);
  // relied on in normal mode; violations are still caught here
  assign unready = (is_send & ~input_ready) | (is_fetch & ~output_ready_flag);
  // Head data keeps stale bytes after a pop, so only the head valid flop may qualify it
  assign rx_valid = rx_word_valid;
  assign rx_data = rx_word[`WS_DATA_MSB:`WS_DATA_LSB];
  assign rx_end = rx_word[`WS_END_BIT];

  byte_buffer #(.WIDTH(9)) in_buf (
    .clk(clk),
    .nrst(nrst),
    .s_valid(in_push),
    .s_ready(in_room),
    .s_data(in_word),
    .m_valid(rx_word_valid),
    .m_ready(rx_ready),
    .m_data(rx_word)
  );

  byte_buffer #(.WIDTH(9)) out_buf (
    .clk(clk),
    .nrst(nrst),
    .s_valid(tx_valid),
    .s_ready(tx_ready),
    .s_data({tx_end, tx_data}),
    .m_valid(out_valid),
    .m_ready(out_pop),
    .m_data(out_word)
  );

  stall_timer stall (
    .clk(clk),
    .nrst(nrst),
    .start(timer_start),
    .expired(timer_expired)
  );

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      held_word <= 16'h0000;
      in_push <= 1'b0;
      in_word <= 9'h000;
      out_pop <= 1'b0;
      fetch_pending <= 1'b0;
      timer_start <= 1'b0;
      cmd_ack <= 1'b0;
      cmd_berr <= 1'b0;
      data_low <= 16'h0000;
      write_ready <= `WS_RST_WRITE_READY;
      read_ready <= `WS_RST_READ_READY;
      input_ready <= 1'b0;
      output_ready_flag <= 1'b0;
      err_n <= `WS_RST_ERR_N;
      fast_mode_active_n <= `WS_RST_FAST_N;
      other_valid <= 1'b0;
      other_word <= 16'h0000;
    end else begin
      in_push <= 1'b0;
      out_pop <= 1'b0;
      timer_start <= 1'b0;
      cmd_ack <= 1'b0;
      cmd_berr <= 1'b0;
      other_valid <= 1'b0;
      // flags only fall through our own push or pop, never with write-ready high
      input_ready <= in_room;
      output_ready_flag <= out_valid;
      if (resp_read) begin
        read_ready <= 1'b0;
      end
      if (err_clear) begin
        err_n <= 1'b1;
      end
      if (fast_request && fast_capable && state == ST_IDLE && write_ready && err_n &&
          (input_ready || output_ready_flag)) begin
        fast_mode_active_n <= 1'b0;
      end
      if (!fast_capable) begin
        fast_mode_active_n <= 1'b1;
      end
      case (state)
        ST_IDLE, ST_STALL: begin
          if ((state == ST_STALL) || (cmd_write && write_ready)) begin
            if (unready) begin
              if (fast_capable && state == ST_IDLE && cmd_fast && !fast_mode_active_n) begin
                held_word <= cmd_word;
                timer_start <= 1'b1;
                state <= ST_STALL;
              // A stale expiry left by an earlier stall must not end a fresh one
              end else if (fast_capable &&
                  (state == ST_IDLE || (timer_expired && !timer_start))) begin
                cmd_berr <= 1'b1;
                fast_mode_active_n <= 1'b1;
                state <= ST_IDLE;
              end else if (!fast_capable) begin
                // Not executed; a normal-mode violation is reported as a protocol error
                err_n <= 1'b0;
                read_ready <= 1'b0;
                write_ready <= 1'b0;
                state <= ST_SETTLE;
              end
            end else begin
              cmd_ack <= 1'b1;
              write_ready <= 1'b0;
              state <= ST_SETTLE;
              if (is_send) begin
                in_push <= 1'b1;
                in_word <= cur_word[8:0];
                if (cur_word[`WS_END_BIT]) begin
                  fast_mode_active_n <= 1'b1;
                end
              end else if (is_fetch) begin
                out_pop <= 1'b1;
                fetch_pending <= 1'b1;
                data_low <= {7'h00, out_word};
                if (out_word[8]) begin
                  fast_mode_active_n <= 1'b1;
                end
              end else begin
                // normal commands always reach the handler
                // no other data protocol competes for them
                other_valid <= 1'b1;
                other_word <= cur_word;
              end
            end
          end
        end
        ST_SETTLE: begin
          // Buffer state moves on this edge; the flags follow on the next
          state <= ST_RELEASE;
        end
        ST_RELEASE: begin
          write_ready <= 1'b1;
          if (fetch_pending) begin
            read_ready <= 1'b1;
          end
          fetch_pending <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- rtl/wsbt_map.vh ----
// Constants for the word serial byte transfer servant.
// Assumes a 100 MHz clock and 16-bit command words written to the low data register.
`ifndef WSBT_MAP_VH
`define WSBT_MAP_VH

// Command word layout: opcode field, message-end bit, data byte
`define WS_OP_MSB 15
`define WS_OP_LSB 9
`define WS_OP_W 7
`define WS_END_BIT 8
`define WS_DATA_MSB 7
`define WS_DATA_LSB 0

// Opcodes of the two byte commands
`define WS_OP_SEND_BYTE 7'h01
`define WS_OP_FETCH_BYTE 7'h02

// Fast handshake stall limit
`define WS_STALL_US 20
`define WS_CLK_MHZ 100
`define WS_STALL_CYCLES (`WS_STALL_US * `WS_CLK_MHZ)
`define WS_STALL_CNT_W 12

// Reset values of the response flags
`define WS_RST_WRITE_READY 1'b1
`define WS_RST_READ_READY 1'b0
`define WS_RST_ERR_N 1'b1
`define WS_RST_FAST_N 1'b1

`endif

// ---- verif/commander_model.sv ----
// Commander side of the command port: writes command words, reads responses.
// Assumes signals change at the falling clock edge.
`timescale 1ns/1ps
module commander_model (
  input wire clk, // Clock
  input wire write_ready, // Servant flag
  input wire read_ready, // Servant flag
  input wire cmd_ack, // Done
  input wire cmd_berr, // Bus error
  output reg cmd_write = 1'b0, // Strobe
  output reg [15:0] cmd_word = 16'h0000, // Word
  output reg cmd_fast = 1'b0, // Fast access
  output reg resp_read = 1'b0 // Response read
);
  // Result: 1 ack, 2 bus error, 0 nothing came
  task issue(input [15:0] w, input f, output [1:0] r);
    integer n;
    begin
      r = 2'h0;
      n = 0;
      while (!write_ready && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      cmd_write = 1'b1;
      cmd_word = w;
      cmd_fast = f;
      @(negedge clk);
      cmd_write = 1'b0;
      cmd_fast = 1'b0;
      cmd_word = ~w;
      n = 0;
      while (r == 2'h0 && n < 2100) begin
        if (cmd_ack) r = 2'h1;
        else if (cmd_berr) r = 2'h2;
        else @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task take;
    integer n;
    begin
      n = 0;
      while (!read_ready && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      resp_read = 1'b1;
      @(negedge clk);
      resp_read = 1'b0;
    end
  endtask
endmodule

// ---- verif/word_serial_byte_transfer_test.sv ----
// Testbench for the word serial byte transfer servant.
// Assumes the commander model drives the command port; the bench plays the device core.
`timescale 1ns/1ps
module word_serial_byte_transfer_test;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg fast_capable = 1'b0, fast_request = 1'b0, err_clear = 1'b0, rx_ready = 1'b0;
  reg tx_valid = 1'b0, tx_end = 1'b0;
  reg [7:0] tx_data = 8'h00;
  wire cmd_write, cmd_fast, resp_read, cmd_ack, cmd_berr, write_ready, read_ready;
  wire input_ready, output_ready_flag, err_n, fast_mode_active_n, other_valid;
  wire rx_valid, rx_end, tx_ready;
  wire [15:0] cmd_word, data_low, other_word;
  wire [7:0] rx_data;
  integer fail_count = 0, checks_done = 0, k;
  reg [1:0] r;
  reg [15:0] last_other;
  always #5 clk = ~clk;
  always @(posedge clk) if (other_valid) last_other <= other_word;
  word_serial_byte_transfer i_dut (.clk(clk), .nrst(nrst), .cmd_write(cmd_write),
    .cmd_word(cmd_word), .cmd_fast(cmd_fast), .resp_read(resp_read), .cmd_ack(cmd_ack),
    .cmd_berr(cmd_berr), .data_low(data_low), .write_ready(write_ready),
    .read_ready(read_ready), .input_ready(input_ready), .output_ready_flag(output_ready_flag),
    .err_n(err_n), .fast_mode_active_n(fast_mode_active_n), .fast_capable(fast_capable),
    .fast_request(fast_request), .err_clear(err_clear), .other_valid(other_valid),
    .other_word(other_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_end(tx_end));
  commander_model i_cmdr (.clk(clk), .write_ready(write_ready), .read_ready(read_ready),
    .cmd_ack(cmd_ack), .cmd_berr(cmd_berr), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .cmd_fast(cmd_fast), .resp_read(resp_read));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Takes two received bytes with the receiver stalled beforehand
  task drain(input [7:0] base, input e);
    integer n;
    begin
      rx_ready = 1'b1;
      n = 0;
      // The head is compared before the rising edge that pops it
      while (n < 2) begin
        if (rx_valid) begin
          chk({rx_end, rx_data}, {n[0] & e, base + n[7:0]});
          n = n + 1;
        end
        @(negedge clk);
      end
      rx_ready = 1'b0;
    end
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    fail_count = fail_count + 1;
    results();
  end
  initial begin
    repeat (4) @(negedge clk);
    chk({write_ready, read_ready, input_ready, output_ready_flag, err_n, fast_mode_active_n,
      tx_ready, rx_valid}, 16'h008E);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    for (k = 0; k < 2; k = k + 1) begin
      i_cmdr.issue({7'h01, k[0], 8'hA0 + k[7:0]}, 1'b0, r);
      chk(r, 2'h1);
    end
    repeat (4) @(negedge clk);
    chk(input_ready, 1'h0);
    fast_capable = 1'b1;
    i_cmdr.issue(16'h03A2, 1'b0, r);
    chk(r, 2'h2);
    chk({err_n, input_ready, read_ready}, 3'h4);
    drain(8'hA0, 1'b1);
    repeat (4) @(negedge clk);
    chk(input_ready, 1'h1);
    tx_data = 8'h5C;
    tx_end = 1'b1;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(output_ready_flag, 1'h1);
    i_cmdr.issue(16'h0400, 1'b0, r);
    i_cmdr.take();
    chk(data_low, 16'h015C);
    chk({r, output_ready_flag}, 3'h2);
    i_cmdr.issue(16'h2055, 1'b0, r);
    repeat (2) @(negedge clk);
    chk(last_other, 16'h2055);
    fast_request = 1'b1;
    @(negedge clk);
    fast_request = 1'b0;
    @(negedge clk);
    chk(fast_mode_active_n, 1'h0);
    chk({write_ready, input_ready, err_n, fast_mode_active_n}, 4'hE);
    for (k = 0; k < 2; k = k + 1) begin
      i_cmdr.issue({8'h02, 8'hB0 + k[7:0]}, 1'b1, r);
      chk(r, 2'h1);
    end
    i_cmdr.issue(16'h02B2, 1'b1, r);
    @(negedge clk);
    chk(r, 2'h2);
    chk(fast_mode_active_n, 1'h1);
    drain(8'hB0, 1'b0);
    repeat (4) @(negedge clk);
    chk(rx_valid, 1'h0);
    // fast accesses resume only once fast mode is offered again
    tx_data = 8'h3D;
    tx_end = 1'b1;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    repeat (4) @(negedge clk);
    fast_request = 1'b1;
    @(negedge clk);
    fast_request = 1'b0;
    @(negedge clk);
    chk({write_ready, output_ready_flag, err_n, fast_mode_active_n}, 4'hE);
    i_cmdr.issue(16'h0400, 1'b1, r);
    chk(r, 2'h1);
    i_cmdr.take();
    chk(data_low, 16'h013D);
    chk(fast_mode_active_n, 1'h1);
    fast_capable = 1'b0;
    i_cmdr.issue(16'h0400, 1'b0, r);
    repeat (4) @(negedge clk);
    chk({err_n, read_ready}, 2'h0);
    err_clear = 1'b1;
    @(negedge clk);
    err_clear = 1'b0;
    @(negedge clk);
    chk(err_n, 1'h1);
    results();
  end
endmodule

// ---- verif/wsbt_properties.sv ----
// Port checker for the word serial byte transfer servant.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module wsbt_properties (
  input wire clk, // Clock
  input wire nrst, // Reset
  input wire cmd_write, // Strobe
  input wire [15:0] cmd_word, // Word
  input wire cmd_ack, // Done
  input wire cmd_berr, // Bus error
  input wire [15:0] data_low, // Response
  input wire write_ready, // Flag
  input wire read_ready, // Flag
  input wire input_ready, // Flag
  input wire output_ready_flag, // Flag
  input wire err_n, // Flag
  input wire fast_mode_active_n, // Flag
  input wire other_valid // Handler strobe
);
  reg pend;
  reg [11:0] wait_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Counts how long an accepted access waits, since a stall may exceed any delay range
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      wait_cnt <= 12'h000;
    // A refused normal-mode command gets no answer; write ready falling ends the wait
    end else if (cmd_ack || cmd_berr || !write_ready) begin
      pend <= 1'b0;
      wait_cnt <= 12'h000;
    end else if (cmd_write && write_ready) begin
      pend <= 1'b1;
    end else if (pend) begin
      wait_cnt <= wait_cnt + 12'h001;
    end
  end
  a_stall_bound: assert property (wait_cnt <= 12'h7D5)
    else $error("access held off too long");
  a_ack_berr_excl: assert property (!(cmd_ack && cmd_berr))
    else $error("ack and bus error together");
  a_ack_wr_low: assert property (cmd_ack |-> !write_ready [*2])
    else $error("write ready back too early");
  a_in_fall_hold: assert property ($fell(input_ready) |-> !$past(write_ready))
    else $error("input ready fell while write ready");
  a_out_fall_hold: assert property ($fell(output_ready_flag) |-> !$past(write_ready))
    else $error("output ready fell while write ready");
  a_berr_keeps_flags: assert property (cmd_berr |-> $stable(err_n) && $stable(read_ready)
    ##1 $stable(err_n) && $stable(read_ready))
    else $error("flags changed on bus error");
  a_berr_fast_exit: assert property (cmd_berr |-> ##[0:1] fast_mode_active_n)
    else $error("fast mode kept after bus error");
  a_fast_entry_ok: assert property ($fell(fast_mode_active_n) |-> $past(write_ready)
    && $past(err_n) && ($past(input_ready) || $past(output_ready_flag)))
    else $error("fast mode entered while unready");
  a_resp_loaded: assert property ($rose(read_ready) |-> $stable(data_low))
    else $error("response word not settled");
  a_other_fwd: assert property (cmd_write && write_ready && cmd_word[15:9] != 7'h01
    && cmd_word[15:9] != 7'h02 |-> ##[1:2] other_valid)
    else $error("command not passed on");
endmodule
bind word_serial_byte_transfer wsbt_properties i_props (.clk(clk), .nrst(nrst),
  .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_ack(cmd_ack), .cmd_berr(cmd_berr),
  .data_low(data_low), .write_ready(write_ready), .read_ready(read_ready),
  .input_ready(input_ready), .output_ready_flag(output_ready_flag), .err_n(err_n),
  .fast_mode_active_n(fast_mode_active_n), .other_valid(other_valid));
